// File: verilog/dma_end_regs.svh
// register offsets, field positions and reset values of the two-channel
// transfer-end control block; included by the main module, the checker and the bench
`ifndef DMA_END_REGS_SVH
`define DMA_END_REGS_SVH

`define CTRL0_OFS      8'h00
`define VEC0_OFS       8'h04
`define CTRL1_OFS      8'h08
`define VEC1_OFS       8'h0C

`define SENSE_POS      6
`define POLARITY_POS   5
`define BUS_HOLD_POS   4
`define ADDR_MODE_POS  3
`define IRQ_EN_POS     2
`define END_FLAG_POS   1
`define CHAN_EN_POS    0

`define CTRL_RESET     8'h00
`define VEC_WIDTH      8

`endif

// File: verilog/dma_end_pkg.sv
// types shared by the transfer-end control block and its request detector
// assumes dma_end_regs.svh on the include path
package dma_end_pkg;

	typedef enum logic {CH_IDLE, CH_UNIT} chan_state_t;

	typedef struct packed {
		logic        request_sense_select;
		logic        request_polarity;
		logic        bus_hold_mode;
		logic        address_count_mode;
		logic        end_irq_enable;
		logic        transfer_end_flag;
		logic        channel_enable;
		logic        end_flag_armed;
		logic        bursting;
		chan_state_t state;
	} chan_t;

	typedef struct packed {
		logic prev_level;
		logic edge_seen;
	} sense_t;

endpackage

// File: verilog/request_sense.sv
// request detector of one channel: level or edge, either polarity
// assumes the request input is synchronous to REF_CLK
`timescale 1ns/1ns
`default_nettype none

module request_sense
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic req_in,
	input  wire logic sense_edge,
	input  wire logic polarity,
	input  wire logic consume,
	output logic      req_active
);

	dma_end_pkg::sense_t s_reg;
	dma_end_pkg::sense_t s_next;
	logic                asserted;
	logic                edge_hit;

	always_comb
	begin
		// polarity 1 means high level or rising edge
		asserted = polarity ? req_in : ~req_in;
		edge_hit = polarity ? (req_in & ~s_reg.prev_level) : (~req_in & s_reg.prev_level);
		s_next = s_reg;
		s_next.prev_level = req_in;
		// a new edge in the consuming cycle stays pending
		if (consume)
			s_next.edge_seen = 1'b0;
		if (edge_hit && sense_edge)
			s_next.edge_seen = 1'b1;
		req_active = sense_edge ? s_reg.edge_seen : asserted;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

endmodule // request_sense

`default_nettype wire

// File: verilog/dma_end_ctrl.sv
// two-channel control and transfer-end interrupt logic of a DMA controller
// assumes an outside datapath that moves one unit per UNIT_GO and answers
// with UNIT_DONE, and an operation register that supplies the enable/abort levels
`timescale 1ns/1ns
`default_nettype none

`include "dma_end_regs.svh"

module dma_end_ctrl
#(
	parameter int CHANNELS = 2
)
(
	input  wire logic                                REF_CLK,
	input  wire logic                                RST_N,
	input  wire logic                                STANDBY,
	input  wire logic                                MODULE_STANDBY,
	input  wire logic [7:0]                          ADDR,
	input  wire logic [31:0]                         WDATA,
	input  wire logic                                WR,
	input  wire logic                                RD,
	output logic      [31:0]                         RDATA,
	input  wire logic                                MASTER_DMA_ENABLE,
	input  wire logic                                NONMASKABLE_ABORT_FLAG,
	input  wire logic                                ADDR_ERROR_FLAG,
	input  wire logic [CHANNELS-1:0]                 AUTO_REQUEST,
	input  wire logic [CHANNELS-1:0]                 TRANSFER_REQUEST_IN,
	input  wire logic [CHANNELS-1:0]                 UNIT_DONE,
	input  wire logic [CHANNELS-1:0]                 COUNT_REMAINING_ZERO,
	output logic      [CHANNELS-1:0]                 UNIT_GO,
	output logic      [CHANNELS-1:0]                 CHANNEL_BUSY,
	output logic      [CHANNELS-1:0]                 BURST_MODE,
	output logic      [CHANNELS-1:0]                 SINGLE_ADDRESS,
	output logic      [CHANNELS-1:0]                 END_IRQ_REQUEST,
	output logic      [CHANNELS-1:0][`VEC_WIDTH-1:0] END_VECTOR
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dma_end_pkg::chan_t [CHANNELS-1:0]                 ch_reg;
	dma_end_pkg::chan_t [CHANNELS-1:0]                 ch_next;
	logic               [CHANNELS-1:0][`VEC_WIDTH-1:0] vec_reg;
	logic               [CHANNELS-1:0][`VEC_WIDTH-1:0] vec_next;
	logic               [31:0]                         rdata_reg;
	logic               [31:0]                         rdata_next;
	logic               [CHANNELS-1:0]                 req_active;
	logic               [CHANNELS-1:0]                 consume;
	logic               [CHANNELS-1:0]                 go;

	// ----------------------------------------------------------------
	// request detectors, one per channel
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_sense
			request_sense u_sense
			(
				.clk        (REF_CLK),
				.rst_n      (RST_N),
				.req_in     (TRANSFER_REQUEST_IN[gi]),
				.sense_edge (ch_reg[gi].request_sense_select),
				.polarity   (ch_reg[gi].request_polarity),
				.consume    (consume[gi]),
				.req_active (req_active[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// channel control, register access
	// ----------------------------------------------------------------
	function automatic logic [7:0] ctrl_image(input dma_end_pkg::chan_t c);
		logic [7:0] v;
		v = `CTRL_RESET;
		v[`SENSE_POS]     = c.request_sense_select;
		v[`POLARITY_POS]  = c.request_polarity;
		v[`BUS_HOLD_POS]  = c.bus_hold_mode;
		v[`ADDR_MODE_POS] = c.address_count_mode;
		v[`IRQ_EN_POS]    = c.end_irq_enable;
		v[`END_FLAG_POS]  = c.transfer_end_flag;
		v[`CHAN_EN_POS]   = c.channel_enable;
		return v;
	endfunction

	always_comb
	begin
		logic       ctrl_hit;
		logic       vec_hit;
		logic       start_ok;
		logic       want;
		logic       stop;
		logic       set_end;
		logic [7:0] ctrl_ofs;
		logic [7:0] vec_ofs;
		ctrl_hit   = 1'b0;
		vec_hit    = 1'b0;
		start_ok   = 1'b0;
		want       = 1'b0;
		stop       = 1'b0;
		set_end    = 1'b0;
		ctrl_ofs   = 8'h00;
		vec_ofs    = 8'h00;
		ch_next    = ch_reg;
		vec_next   = vec_reg;
		rdata_next = 32'h0000_0000;   // unmapped reads answer zero
		consume    = '0;
		go         = '0;
		for (int c = 0; c < CHANNELS; c++)
		begin
			ctrl_ofs = c[0] ? `CTRL1_OFS : `CTRL0_OFS;
			vec_ofs  = c[0] ? `VEC1_OFS : `VEC0_OFS;
			ctrl_hit = (ADDR == ctrl_ofs);
			vec_hit  = (ADDR == vec_ofs);

			// aborts and enables are looked at on every cycle
			stop     = ~ch_reg[c].channel_enable | ~MASTER_DMA_ENABLE
			           | NONMASKABLE_ABORT_FLAG | ADDR_ERROR_FLAG;
			start_ok = ~stop & ~ch_reg[c].transfer_end_flag & ~MODULE_STANDBY;
			want     = AUTO_REQUEST[c] | ch_reg[c].bursting | req_active[c];
			set_end  = 1'b0;

			case (ch_reg[c].state)
				dma_end_pkg::CH_IDLE:
				begin
					if (stop)
						ch_next[c].bursting = 1'b0;
					else if (start_ok && want)
					begin
						go[c]                = 1'b1;
						consume[c]           = 1'b1;
						// burst keeps the bus once the first request is seen
						ch_next[c].bursting  = ch_reg[c].bus_hold_mode;
						ch_next[c].state     = dma_end_pkg::CH_UNIT;
					end
				end
				dma_end_pkg::CH_UNIT:
				begin
					if (stop)
					begin
						// aborted: flag stays clear whatever the count
						ch_next[c].bursting = 1'b0;
						ch_next[c].state    = dma_end_pkg::CH_IDLE;
					end
					else if (UNIT_DONE[c])
					begin
						ch_next[c].state = dma_end_pkg::CH_IDLE;
						if (COUNT_REMAINING_ZERO[c])
						begin
							set_end             = 1'b1;
							ch_next[c].bursting = 1'b0;
						end
					end
				end
				default:
					ch_next[c].state = dma_end_pkg::CH_IDLE;
			endcase

			if (RD && ctrl_hit)
			begin
				rdata_next[7:0] = ctrl_image(ch_reg[c]);
				// reading the flag as 1 arms the clearing write
				if (ch_reg[c].transfer_end_flag)
					ch_next[c].end_flag_armed = 1'b1;
			end
			if (RD && vec_hit)
				rdata_next[`VEC_WIDTH-1:0] = vec_reg[c];

			if (WR && ctrl_hit)
			begin
				ch_next[c].request_sense_select = WDATA[`SENSE_POS];
				ch_next[c].request_polarity     = WDATA[`POLARITY_POS];
				ch_next[c].bus_hold_mode        = WDATA[`BUS_HOLD_POS];
				ch_next[c].address_count_mode   = WDATA[`ADDR_MODE_POS];
				ch_next[c].end_irq_enable       = WDATA[`IRQ_EN_POS];
				ch_next[c].channel_enable       = WDATA[`CHAN_EN_POS];
				if (ch_reg[c].end_flag_armed && !WDATA[`END_FLAG_POS])
				begin
					ch_next[c].transfer_end_flag = 1'b0;
					ch_next[c].end_flag_armed    = 1'b0;
				end
			end
			// only the low byte holds state; the top vector bit is software's care
			if (WR && vec_hit)
				vec_next[c] = WDATA[`VEC_WIDTH-1:0];

			// a completion in the clearing cycle wins
			if (set_end)
				ch_next[c].transfer_end_flag = 1'b1;

			// standby clears the control word but never the vector
			if (STANDBY)
				ch_next[c] = '0;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ch_reg    <= '0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ch_reg    <= ch_next;
			rdata_reg <= rdata_next;
		end
	end

	// no reset on purpose: the vector survives chip reset and standby
	always_ff @(posedge REF_CLK)
	begin
		vec_reg <= vec_next;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int c = 0; c < CHANNELS; c++)
		begin
			CHANNEL_BUSY[c]    = (ch_reg[c].state == dma_end_pkg::CH_UNIT);
			BURST_MODE[c]      = ch_reg[c].bus_hold_mode;
			SINGLE_ADDRESS[c]  = ch_reg[c].address_count_mode;
			END_IRQ_REQUEST[c] = ch_reg[c].transfer_end_flag & ch_reg[c].end_irq_enable;
		end
	end

	// vector is unknown until written, as software must program it
	assign END_VECTOR = vec_reg;
	assign UNIT_GO    = go;
	assign RDATA      = rdata_reg;

endmodule // dma_end_ctrl

`default_nettype wire

// File: dv/dma_far_model.sv
// far side model: request pins and a one-unit datapath per channel
// assumes the bench sets cnt before enabling a channel
`timescale 1ns/1ns
`default_nettype none
module dma_far_model
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] unit_go,
	input  wire logic [1:0] want,
	input  wire logic       hi,
	input  wire logic [2:0] lat,
	output logic      [1:0] unit_done,
	output logic      [1:0] count_zero,
	output logic      [1:0] req_pin
);
	logic [1:0][7:0] cnt;
	logic [1:0][2:0] w;
	// request shown at the chosen level or edge direction
	assign req_pin = ~(want ^ {2{hi}});
	assign count_zero = {cnt[1] == 8'h00, cnt[0] == 8'h00};
	// lat of 0 would never answer; the bench keeps it at 1 or more
	always @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			w <= '0;
			unit_done <= 2'h0;
		end
		else
			for (int i = 0; i < 2; i++)
			begin
				unit_done[i] <= (w[i] == 3'h1);
				if (unit_go[i])
				begin
					w[i] <= lat;
					cnt[i] <= cnt[i] - 8'h01;
				end
				else if (w[i] != 3'h0)
					w[i] <= w[i] - 3'h1;
			end
endmodule // dma_far_model
`default_nettype wire

// File: dv/dma_end_ctrl_asserts.sv
// port checker of the transfer-end control block
// bound from the bench top file
`timescale 1ns/1ns
`default_nettype none
`include "dma_end_regs.svh"
module dma_end_ctrl_asserts
#(
	parameter int CHANNELS = 2
)
(
	input wire logic                                REF_CLK,
	input wire logic                                RST_N,
	input wire logic                                STANDBY,
	input wire logic                                MODULE_STANDBY,
	input wire logic [7:0]                          ADDR,
	input wire logic [31:0]                         WDATA,
	input wire logic                                WR,
	input wire logic                                RD,
	input wire logic [31:0]                         RDATA,
	input wire logic                                MASTER_DMA_ENABLE,
	input wire logic                                NONMASKABLE_ABORT_FLAG,
	input wire logic                                ADDR_ERROR_FLAG,
	input wire logic [CHANNELS-1:0]                 UNIT_GO,
	input wire logic [CHANNELS-1:0]                 CHANNEL_BUSY,
	input wire logic [CHANNELS-1:0]                 BURST_MODE,
	input wire logic [CHANNELS-1:0]                 SINGLE_ADDRESS,
	input wire logic [CHANNELS-1:0]                 END_IRQ_REQUEST,
	input wire logic [CHANNELS-1:0][`VEC_WIDTH-1:0] END_VECTOR
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	property p_go_en;
		UNIT_GO[0] |-> MASTER_DMA_ENABLE && !NONMASKABLE_ABORT_FLAG && !ADDR_ERROR_FLAG && !MODULE_STANDBY;
	endproperty
	a_go_en: assert property (p_go_en) else $error("start without enables");
	property p_go_busy;
		UNIT_GO[0] && !STANDBY |=> CHANNEL_BUSY[0];
	endproperty
	a_go_busy: assert property (p_go_busy) else $error("start not followed by busy");
	property p_flag_block;
		END_IRQ_REQUEST[0] |-> !UNIT_GO[0];
	endproperty
	a_flag_block: assert property (p_flag_block) else $error("start with end flag set");
	property p_abort;
		CHANNEL_BUSY[0] && !MASTER_DMA_ENABLE && !END_IRQ_REQUEST[0] |=> (!CHANNEL_BUSY[0] && !END_IRQ_REQUEST[0]) [*2];
	endproperty
	a_abort: assert property (p_abort) else $error("abort left busy or end set");
	property p_mode;
		WR && ADDR == `CTRL0_OFS && !STANDBY |=> BURST_MODE[0] == $past(WDATA[4]) && SINGLE_ADDRESS[0] == $past(WDATA[3]);
	endproperty
	a_mode: assert property (p_mode) else $error("mode outputs differ from write");
	property p_vec;
		WR && ADDR == `VEC1_OFS |=> END_VECTOR[1] == $past(WDATA[7:0]);
	endproperty
	a_vec: assert property (p_vec) else $error("vector output differs from write");
	property p_vec_hi;
		RD && ADDR == `VEC0_OFS |=> RDATA[31:8] == 24'h0;
	endproperty
	a_vec_hi: assert property (p_vec_hi) else $error("vector upper bits not zero");
	property p_standby;
		STANDBY |=> CHANNEL_BUSY == '0 && BURST_MODE == '0 && END_IRQ_REQUEST == '0;
	endproperty
	a_standby: assert property (p_standby) else $error("standby left state");
endmodule // dma_end_ctrl_asserts
`default_nettype wire

// File: dv/dma_end_ctrl_tb_top.sv
// self-checking bench of the transfer-end control block
// assumes the far side model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "dma_end_regs.svh"
module dma_end_ctrl_tb_top;
	logic            REF_CLK = 1'b0;
	logic            RST_N, STANDBY, MODULE_STANDBY, WR, RD, MASTER_DMA_ENABLE, NONMASKABLE_ABORT_FLAG, ADDR_ERROR_FLAG;
	logic [7:0]      ADDR;
	logic [31:0]     WDATA, RDATA, d;
	logic [1:0]      AUTO_REQUEST, TRANSFER_REQUEST_IN, UNIT_DONE, COUNT_REMAINING_ZERO, want;
	logic [1:0]      UNIT_GO, CHANNEL_BUSY, BURST_MODE, SINGLE_ADDRESS, END_IRQ_REQUEST;
	logic [1:0][7:0] END_VECTOR;
	logic            hi;
	logic [2:0]      lat;
	int              bad_count = 0, total_checks = 0, gos[2] = '{0, 0};
	always #50 REF_CLK = ~REF_CLK;
	always @(posedge REF_CLK) for (int i = 0; i < 2; i++) if (UNIT_GO[i] === 1'b1) gos[i]++;
	dma_end_ctrl u_dma_end_ctrl (.REF_CLK, .RST_N, .STANDBY, .MODULE_STANDBY, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.MASTER_DMA_ENABLE, .NONMASKABLE_ABORT_FLAG, .ADDR_ERROR_FLAG, .AUTO_REQUEST, .TRANSFER_REQUEST_IN,
		.UNIT_DONE, .COUNT_REMAINING_ZERO, .UNIT_GO, .CHANNEL_BUSY, .BURST_MODE, .SINGLE_ADDRESS, .END_IRQ_REQUEST,
		.END_VECTOR);
	dma_far_model u_dma_far_model (.clk(REF_CLK), .rst_n(RST_N), .unit_go(UNIT_GO), .want(want), .hi(hi),
		.lat(lat), .unit_done(UNIT_DONE), .count_zero(COUNT_REMAINING_ZERO), .req_pin(TRANSFER_REQUEST_IN));
	//----------------------------------------
	// bus tasks
	//----------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1 d = RDATA;
		chk(n, e, d);
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#3000000;
		bad_count++;
		stop_test;
	end
	initial
	begin
		{RST_N, STANDBY, MODULE_STANDBY, WR, RD, NONMASKABLE_ABORT_FLAG, ADDR_ERROR_FLAG} = '0;
		{ADDR, WDATA, AUTO_REQUEST, want} = '0;
		{MASTER_DMA_ENABLE, hi, lat} = 5'h13;
		cyc(5);
		RST_N <= 1'b1;
		rc("ctrl0", `CTRL0_OFS, 32'h0);
		rc("ctrl1", `CTRL1_OFS, 32'h0);
		rc("unmapped", 8'h10, 32'h0);
		wr(`VEC0_OFS, 32'h45);
		wr(`VEC1_OFS, 32'h7E);
		rc("vec0", `VEC0_OFS, 32'h45);
		chk("vec0 out", 32'h45, END_VECTOR[0]);
		u_dma_far_model.cnt[0] = 8'h02;
		AUTO_REQUEST <= 2'h3;
		wr(`CTRL0_OFS, 32'h05);
		cyc(12);
		chk("irq0", 32'h1, END_IRQ_REQUEST[0]);
		chk("units0", 32'h2, gos[0]);
		wr(`CTRL0_OFS, 32'h04);
		rc("unarmed", `CTRL0_OFS, 32'h06);
		wr(`CTRL0_OFS, 32'h07);
		cyc(6);
		rc("write one", `CTRL0_OFS, 32'h07);
		chk("blocked", 32'h2, gos[0]);
		wr(`CTRL0_OFS, 32'h04);
		rc("cleared", `CTRL0_OFS, 32'h04);
		chk("irq0 off", 32'h0, END_IRQ_REQUEST[0]);
		u_dma_far_model.cnt[1] = 8'h03;
		lat <= 3'h4;
		wr(`CTRL1_OFS, 32'h59);
		cyc(30);
		chk("burst1", 32'h1, BURST_MODE[1]);
		chk("single1", 32'h1, SINGLE_ADDRESS[1]);
		chk("irq1", 32'h0, END_IRQ_REQUEST[1]);
		chk("units1", 32'h3, gos[1]);
		chk("units0 kept", 32'h2, gos[0]);
		rc("ctrl1 end", `CTRL1_OFS, 32'h5B);
		AUTO_REQUEST <= 2'h2;
		lat <= 3'h1;
		// edge rising, then level low; a held request gives one unit only
		for (int i = 0; i < 2; i++)
		begin
			automatic int b = gos[0];
			u_dma_far_model.cnt[0] <= 8'h01;
			hi <= (i == 0);
			wr(`CTRL0_OFS, i ? 32'h01 : 32'h61);
			cyc(4);
			chk("idle pin", b, gos[0]);
			want <= 2'h1;
			cyc(10);
			chk("one unit", b + 1, gos[0]);
			rc("req end", `CTRL0_OFS, i ? 32'h03 : 32'h63);
			wr(`CTRL0_OFS, 32'h00);
			want <= 2'h0;
		end
		AUTO_REQUEST <= 2'h3;
		lat <= 3'h7;
		u_dma_far_model.cnt[0] <= 8'h05;
		wr(`CTRL0_OFS, 32'h05);
		cyc(3);
		MASTER_DMA_ENABLE <= 1'b0;
		cyc(12);
		chk("abort busy", 32'h0, CHANNEL_BUSY[0]);
		rc("abort flag", `CTRL0_OFS, 32'h05);
		MASTER_DMA_ENABLE <= 1'b1;
		cyc(3);
		chk("restart", 32'h1, CHANNEL_BUSY[0]);
		wr(`CTRL0_OFS, 32'h04);
		cyc(1);
		#1 chk("stop", 32'h0, CHANNEL_BUSY[0]);
		rc("stop flag", `CTRL0_OFS, 32'h04);
		// an address error holds the start off; an abort flag stops a unit with count left
		ADDR_ERROR_FLAG <= 1'b1;
		wr(`CTRL0_OFS, 32'h05);
		cyc(3);
		chk("ae block", 32'h6, gos[0]);
		ADDR_ERROR_FLAG <= 1'b0;
		cyc(3);
		chk("ae clear", 32'h7, gos[0]);
		NONMASKABLE_ABORT_FLAG <= 1'b1;
		MODULE_STANDBY <= 1'b1;
		cyc(3);
		chk("nmi busy", 32'h0, CHANNEL_BUSY[0]);
		NONMASKABLE_ABORT_FLAG <= 1'b0;
		cyc(12);
		rc("mstby ctrl", `CTRL0_OFS, 32'h05);
		chk("mstby hold", 32'h7, gos[0]);
		wr(`CTRL0_OFS, 32'h04);
		MODULE_STANDBY <= 1'b0;
		STANDBY <= 1'b1;
		cyc(1);
		STANDBY <= 1'b0;
		rc("standby", `CTRL1_OFS, 32'h0);
		chk("vec1 kept", 32'h7E, END_VECTOR[1]);
		wr(`CTRL1_OFS, 32'h0C);
		cyc(1);
		chk("single1 set", 32'h1, SINGLE_ADDRESS[1]);
		RST_N <= 1'b0;
		cyc(2);
		RST_N <= 1'b1;
		rc("vec0 reset", `VEC0_OFS, 32'h45);
		rc("ctrl1 reset", `CTRL1_OFS, 32'h0);
		stop_test;
	end
endmodule // dma_end_ctrl_tb_top
bind dma_end_ctrl dma_end_ctrl_asserts #(.CHANNELS(CHANNELS)) u_chk (.REF_CLK, .RST_N, .STANDBY, .MODULE_STANDBY,
	.ADDR, .WDATA, .WR, .RD, .RDATA, .MASTER_DMA_ENABLE, .NONMASKABLE_ABORT_FLAG, .ADDR_ERROR_FLAG, .UNIT_GO,
	.CHANNEL_BUSY, .BURST_MODE, .SINGLE_ADDRESS, .END_IRQ_REQUEST, .END_VECTOR);
`default_nettype wire
